// >>> ddrc_pkg.sv
`default_nettype none
package ddrc_pkg;

	// Clock rate and counter width.
	localparam int CLK_PERIOD_PS = 100000;
	localparam int CNT_W         = 11;

	// Whole cycles covering a least time, never under one.
	function automatic int cyc_up(input int ps);
		int n;
		n = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
		return (n < 1) ? 1 : n;
	endfunction

	function automatic int max2(input int a, input int b);
		return (a > b) ? a : b;
	endfunction

	// Register-set settling and mode register spacing.
	localparam int MOD_NCK    = 24;
	localparam int MOD_PS     = 15000;
	localparam int MOD_CYC    = max2(MOD_NCK, cyc_up(MOD_PS));
	localparam int MRD_NCK    = 8;
	localparam int MPRR_NCK   = 1;

	// Chip-select-to-command latency.
	localparam int CAL_NCK    = 3;
	localparam int CAL_PS     = 3748;
	localparam int CAL_CYC    = max2(CAL_NCK, cyc_up(CAL_PS));

	// Deep power save entry and exit.
	localparam int CPDED_NCK  = 4;
	localparam int CKMPE_CYC  = MOD_CYC + CPDED_NCK;
	localparam int CKSRX_NCK  = 5;
	localparam int CKSRX_PS   = 10000;
	localparam int CKMPX_CYC  = max2(CKSRX_NCK, cyc_up(CKSRX_PS));
	localparam int XS_ADD_PS  = 10000;
	localparam int DLLK_NCK   = 768;
	localparam int IS_PS      = 80;
	localparam int IH_PS      = 105;
	localparam int MPX_S_CYC  = cyc_up(IS_PS + IH_PS);
	localparam int XP_NCK     = 4;
	localparam int XP_PS      = 6000;
	localparam int XP_CYC     = max2(XP_NCK, cyc_up(XP_PS));

	// User operations; deep power save entry goes out as a mode register set.
	typedef enum logic [3:0] {
		OP_DES        = 4'h0,
		OP_MRS        = 4'h1,
		OP_MPR_RD     = 4'h2,
		OP_MPR_WR     = 4'h3,
		OP_WRA        = 4'h4,
		OP_ACT        = 4'h5,
		OP_OTHER      = 4'h6,
		OP_DEEP_EXIT  = 4'h7,
		OP_DEEP_ENTER = 4'h8
	} ddrc_op_t;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_CAL   = 3'h1,
		ST_KEEP  = 3'h2,
		ST_DEEP  = 3'h3,
		ST_XCLK  = 3'h4,
		ST_XSET  = 3'h5,
		ST_XHOLD = 3'h6
	} ddrc_state_t;

endpackage
`default_nettype wire

// >>> ddrc_gap_timer.sv
`timescale 1ns/1ps
`default_nettype none
module ddrc_gap_timer #(
	parameter int W = 11
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         sys_rst,
	// Load request
	input  wire logic         load,
	input  wire logic [W-1:0] load_val,
	// Status
	output logic              busy,
	output logic              near_free
);
	logic [W-1:0] cnt_q;
	wire  [W-1:0] dec   = (cnt_q == '0) ? '0 : cnt_q - W'(1);
	wire  [W-1:0] cnt_d = (load && (load_val > dec)) ? load_val : dec;

	// A new load never shortens a wait already running.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign busy      = (cnt_q != '0);
	assign near_free = (cnt_d <= W'(1));

endmodule
`default_nettype wire

// >>> ddrc_host.sv
`timescale 1ns/1ps
`default_nettype none
module ddrc_host
	import ddrc_pkg::*;
#(
	parameter int BANK_W     = 4,
	parameter int RP_PS      = 15000,
	parameter int RFC_PS     = 350000,
	parameter int MPR_RD_NCK = 8
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              sys_rst,
	// User command port
	input  wire logic              cmd_valid,
	input  wire ddrc_op_t          cmd_op,
	input  wire logic [BANK_W-1:0] cmd_bank,
	input  wire logic              cmd_dll,
	output logic                   cmd_ready,
	output logic                   cmd_issued,
	// Settings
	input  wire logic              cal_en,
	input  wire logic [4:0]        wr_nck,
	input  wire logic [4:0]        al_nck,
	input  wire logic [3:0]        pl_nck,
	// Memory pins
	output logic                   ddr_ck_run,
	output logic                   ddr_cke,
	output logic                   ddr_cs_n,
	output ddrc_op_t               ddr_op,
	output logic [BANK_W-1:0]      ddr_bank
);
	localparam int BANKS      = 1 << BANK_W;
	localparam int XMP_CYC    = cyc_up(RFC_PS + XS_ADD_PS);
	localparam int XMPDLL_CYC = XMP_CYC + DLLK_NCK;
	localparam int RP_CYC     = cyc_up(RP_PS);
	localparam int RD_GAP     = MPR_RD_NCK + MPRR_NCK;

	localparam logic [CNT_W-1:0] CAL_M1   = CNT_W'(CAL_CYC - 1);
	localparam logic [CNT_W-1:0] KEEP_M1  = CNT_W'(CKMPE_CYC - 1);
	localparam logic [CNT_W-1:0] CKMPX_M1 = CNT_W'(CKMPX_CYC - 1);
	localparam logic [CNT_W-1:0] MPXS_M1  = CNT_W'(MPX_S_CYC - 1);
	localparam logic [CNT_W-1:0] XP_M1    = CNT_W'(XP_CYC - 1);

	function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
		return (v == '1) ? v : v + CNT_W'(1);
	endfunction

	ddrc_state_t       state_q;
	ddrc_state_t       state_d;
	logic [CNT_W-1:0]  ph_q;
	logic [CNT_W-1:0]  ph_d;
	ddrc_op_t          op_h_q;
	logic [BANK_W-1:0] bank_h_q;
	logic              dll_h_q;
	logic              ready_q;
	logic              issue_q;
	logic              dll_q;
	logic              cal_iss_q;
	logic              cs_n_q;
	logic              cke_q;
	logic              ck_run_q;
	ddrc_op_t          op_q;
	logic [BANK_W-1:0] bank_q;
	ddrc_op_t          iss_op;
	ddrc_op_t          op_d;
	logic              gap_near;
	logic              mod_near;
	logic              dll_near;
	logic [BANKS-1:0]  dal_busy;
	logic [BANKS-1:0]  dal_near;
	logic [BANKS-1:0]  dal_load;

	// Handshake and issue decode.
	wire take       = cmd_valid && ready_q;
	wire from_cal   = (state_q == ST_CAL) && (ph_q == '0);
	wire take_issue = take && !cal_en && (state_q == ST_IDLE);
	wire cal_go     = take && cal_en && (state_q == ST_IDLE);
	wire issue_d    = take_issue || from_cal;
	wire exit_go    = take && (state_q == ST_DEEP);
	wire keep_end   = (state_q == ST_KEEP) && (ph_q == '0);
	wire cke_go     = (state_q == ST_XSET) && (ph_q == '0);
	assign iss_op   = from_cal ? op_h_q : cmd_op;
	wire [BANK_W-1:0] iss_bank = from_cal ? bank_h_q : cmd_bank;
	wire iss_dll    = from_cal ? dll_h_q : cmd_dll;
	wire iss_mrs    = (iss_op == OP_MRS) || (iss_op == OP_DEEP_ENTER);
	wire cmd_mrs    = (cmd_op == OP_MRS) || (cmd_op == OP_DEEP_ENTER);

	// Spacing loads; every wait is rounded up and the longest wins.
	wire [CNT_W-1:0] mprwr_gap = CNT_W'(MOD_CYC) + CNT_W'(al_nck) + CNT_W'(pl_nck);
	wire gap_load = (issue_d && (iss_mrs || (iss_op == OP_MPR_RD) || (iss_op == OP_MPR_WR)))
		|| cke_go;
	wire [CNT_W-1:0] gap_val = cke_go ? CNT_W'(XMP_CYC) :
		(iss_op == OP_MPR_RD) ? CNT_W'(RD_GAP) :
		(iss_op == OP_MPR_WR) ? mprwr_gap :
		CNT_W'(MRD_NCK);
	wire mod_load = issue_d && iss_mrs;
	wire [CNT_W-1:0] dal_val = CNT_W'(wr_nck) + CNT_W'(RP_CYC);

	ddrc_gap_timer #(.W(CNT_W)) u_gap (
		.clk       (clk),
		.sys_rst   (sys_rst),
		.load      (gap_load),
		.load_val  (gap_val),
		.busy      (),
		.near_free (gap_near)
	);

	ddrc_gap_timer #(.W(CNT_W)) u_mod (
		.clk       (clk),
		.sys_rst   (sys_rst),
		.load      (mod_load),
		.load_val  (CNT_W'(MOD_CYC)),
		.busy      (),
		.near_free (mod_near)
	);

	ddrc_gap_timer #(.W(CNT_W)) u_dll (
		.clk       (clk),
		.sys_rst   (sys_rst),
		.load      (cke_go),
		.load_val  (CNT_W'(XMPDLL_CYC)),
		.busy      (),
		.near_free (dll_near)
	);

	genvar gi;
	generate
		for (gi = 0; gi < BANKS; gi++) begin : g_dal
			assign dal_load[gi] = issue_d && (iss_op == OP_WRA) && (iss_bank == BANK_W'(gi));
			ddrc_gap_timer #(.W(CNT_W)) u_dal (
				.clk       (clk),
				.sys_rst   (sys_rst),
				.load      (dal_load[gi]),
				.load_val  (dal_val),
				.busy      (dal_busy[gi]),
				.near_free (dal_near[gi])
			);
		end
	endgenerate

	// Sequencing of command latency and deep power save.
	always_comb begin
		state_d = state_q;
		ph_d    = (ph_q == '0) ? '0 : ph_q - CNT_W'(1);
		unique case (state_q)
			ST_IDLE: begin
				if (cal_go) begin
					state_d = ST_CAL;
					ph_d    = CAL_M1;
				end else if (take_issue && (cmd_op == OP_DEEP_ENTER)) begin
					state_d = ST_KEEP;
					ph_d    = KEEP_M1;
				end
			end
			ST_CAL: begin
				if (ph_q == '0) begin
					state_d = (op_h_q == OP_DEEP_ENTER) ? ST_KEEP : ST_IDLE;
					ph_d    = KEEP_M1;
				end
			end
			ST_KEEP: begin
				if (ph_q == '0) begin
					state_d = ST_DEEP;
				end
			end
			ST_DEEP: begin
				if (exit_go) begin
					state_d = ST_XCLK;
					ph_d    = CKMPX_M1;
				end
			end
			ST_XCLK: begin
				if (ph_q == '0) begin
					state_d = ST_XSET;
					ph_d    = MPXS_M1;
				end
			end
			ST_XSET: begin
				if (ph_q == '0) begin
					state_d = ST_XHOLD;
					ph_d    = XP_M1;
				end
			end
			ST_XHOLD: begin
				if (ph_q == '0) begin
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// Ready looks one cycle ahead at the command held on the port.
	wire idle_ok = (state_d == ST_IDLE) && (cmd_op != OP_DEEP_EXIT) && gap_near
		&& (cmd_mrs || mod_near)
		&& (!cmd_dll || dll_near)
		&& ((cmd_op != OP_ACT) || dal_near[cmd_bank]);
	wire deep_ok = (state_d == ST_DEEP) && (cmd_op == OP_DEEP_EXIT);
	wire ready_d = cmd_valid && !take && (idle_ok || deep_ok);

	// Pin values.
	wire cs_n_d   = !(take_issue || cal_go);
	assign op_d   = !issue_d ? OP_DES : (iss_mrs ? OP_MRS : iss_op);
	wire ck_run_d = exit_go ? 1'b1 : (keep_end ? 1'b0 : ck_run_q);
	wire cke_d    = cke_go ? 1'b1 : (keep_end ? 1'b0 : cke_q);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_q   <= ST_IDLE;
			ph_q      <= '0;
			op_h_q    <= OP_DES;
			bank_h_q  <= '0;
			dll_h_q   <= 1'b0;
			ready_q   <= 1'b0;
			issue_q   <= 1'b0;
			dll_q     <= 1'b0;
			cal_iss_q <= 1'b0;
			cs_n_q    <= 1'b1;
			cke_q     <= 1'b1;
			ck_run_q  <= 1'b1;
			op_q      <= OP_DES;
			bank_q    <= '0;
		end else begin
			state_q   <= state_d;
			ph_q      <= ph_d;
			op_h_q    <= take ? cmd_op : op_h_q;
			bank_h_q  <= take ? cmd_bank : bank_h_q;
			dll_h_q   <= take ? cmd_dll : dll_h_q;
			ready_q   <= ready_d;
			issue_q   <= issue_d;
			dll_q     <= issue_d && iss_dll;
			cal_iss_q <= from_cal;
			cs_n_q    <= cs_n_d;
			cke_q     <= cke_d;
			ck_run_q  <= ck_run_d;
			op_q      <= op_d;
			bank_q    <= issue_d ? iss_bank : bank_q;
		end
	end

	assign cmd_ready  = ready_q;
	assign cmd_issued = issue_q;
	assign ddr_ck_run = ck_run_q;
	assign ddr_cke    = cke_q;
	assign ddr_cs_n   = cs_n_q;
	assign ddr_op     = op_q;
	assign ddr_bank   = bank_q;

	// Cycles since each spacing event, for the checks below.
	logic [CNT_W-1:0] since_mod_q;
	logic [CNT_W-1:0] since_wr_q;
	logic [CNT_W-1:0] since_rd_q;
	logic [CNT_W-1:0] since_exit_q;
	logic [CNT_W-1:0] since_keep_q;
	logic [CNT_W-1:0] since_ckon_q;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			since_mod_q  <= '1;
			since_wr_q   <= '1;
			since_rd_q   <= '1;
			since_exit_q <= '1;
			since_keep_q <= '1;
			since_ckon_q <= '1;
		end else begin
			since_mod_q  <= mod_load ? '0 : sat_inc(since_mod_q);
			since_wr_q   <= (issue_d && (iss_op == OP_MPR_WR)) ? '0 : sat_inc(since_wr_q);
			since_rd_q   <= (issue_d && (iss_op == OP_MPR_RD)) ? '0 : sat_inc(since_rd_q);
			since_exit_q <= cke_go ? '0 : sat_inc(since_exit_q);
			since_keep_q <= (issue_d && (iss_op == OP_DEEP_ENTER)) ? '0 : sat_inc(since_keep_q);
			since_ckon_q <= exit_go ? '0 : sat_inc(since_ckon_q);
		end
	end

	mod_settle_a: assert property (@(posedge clk) disable iff (sys_rst)
		issue_q && (op_q != OP_MRS) |-> since_mod_q >= CNT_W'(MOD_CYC))
		else $error("Command issued inside mode set settling time.");

	mpr_read_gap_a: assert property (@(posedge clk) disable iff (sys_rst)
		issue_q && (since_rd_q != '0) |-> since_rd_q >= CNT_W'(RD_GAP))
		else $error("Command issued inside purpose-register read recovery.");

	mpr_write_gap_a: assert property (@(posedge clk) disable iff (sys_rst)
		issue_q && (since_wr_q != '0) |-> since_wr_q >= $past(mprwr_gap, 1))
		else $error("Command issued inside purpose-register write recovery.");

	act_after_wra_a: assert property (@(posedge clk) disable iff (sys_rst)
		issue_q && (op_q == OP_ACT) |-> !dal_busy[bank_q])
		else $error("Activate issued while auto-close write recovery runs.");

	cal_latency_a: assert property (@(posedge clk) disable iff (sys_rst)
		issue_q && cal_iss_q |-> $past(cs_n_q, 3) == 1'b0 && cs_n_q && $past(cs_n_q, 1))
		else $error("Command does not follow select by the set latency.");

	clock_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
		$fell(ck_run_q) |-> since_keep_q == CNT_W'(CKMPE_CYC))
		else $error("Clock stopped at the wrong time after deep entry.");

	clock_ready_a: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(cke_q) |-> ck_run_q && since_ckon_q >= CNT_W'(CKMPX_CYC))
		else $error("Clock not running long enough before deep exit.");

	exit_plain_a: assert property (@(posedge clk) disable iff (sys_rst)
		issue_q |-> since_exit_q >= CNT_W'(XMP_CYC))
		else $error("Command issued too soon after deep exit.");

	exit_locked_a: assert property (@(posedge clk) disable iff (sys_rst)
		issue_q && dll_q |-> since_exit_q >= CNT_W'(XMPDLL_CYC))
		else $error("Locked-loop command issued too soon after deep exit.");

	select_setup_a: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(cke_q) |-> cs_n_q && $past(cs_n_q, 1) && $past(ck_run_q, 1))
		else $error("Select not stable before clock enable rose.");

	select_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(cke_q) |-> cs_n_q [*4])
		else $error("Select fell too soon after clock enable rose.");

endmodule
`default_nettype wire

// >>> ddrc_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module ddrc_mem_model
	import ddrc_pkg::*;
(
	// Clock and reset
	input  wire logic     clk,
	input  wire logic     sys_rst,
	// Memory pins
	input  wire logic     ddr_cke,
	input  wire ddrc_op_t ddr_op,
	// Status
	output var logic      path_on,
	output var int        n_seen
);
	int since_mrs;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			path_on   <= 1'b1;
			n_seen    <= 0;
			since_mrs <= 0;
		end else begin
			since_mrs <= (ddr_op == OP_MRS) ? 1 : since_mrs + 1;
			// The path only drops once settling and pass-off delay have both run.
			if (!ddr_cke && since_mrs >= MOD_CYC + CPDED_NCK) path_on <= 1'b0;
			else if (ddr_cke) path_on <= 1'b1;
			if (path_on && ddr_op != OP_DES && ddr_op <= OP_OTHER) n_seen <= n_seen + 1;
		end
	end
endmodule
`default_nettype wire

// >>> ddrc_host_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ddrc_host_tb
	import ddrc_pkg::*;
;
	localparam int XMP    = (350000 + 10000 + 99999) / 100000;
	localparam int RP_CYC = (15000 + 99999) / 100000;
	localparam int MPR_RD_NCK = 8;
	logic       clk, sys_rst, cmd_valid, cmd_dll, cal_en, cmd_ready, cmd_issued;
	logic       ddr_ck_run, ddr_cke, ddr_cs_n, path_on, ck_p, rn_p;
	ddrc_op_t   cmd_op, ddr_op;
	logic [3:0] cmd_bank, ddr_bank, pl_nck;
	logic [4:0] wr_nck, al_nck;
	int         cyc = 0;
	int         n_seen, mismatches, total_checks, cs_cyc, up_cyc, run_cyc;
	int         t_mrs, t_rd, t_mw, mw_lat, x_cyc, n_iss;
	int         wra[16];

	ddrc_host u_dut (.clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
		.cmd_bank(cmd_bank), .cmd_dll(cmd_dll), .cmd_ready(cmd_ready), .cmd_issued(cmd_issued),
		.cal_en(cal_en), .wr_nck(wr_nck), .al_nck(al_nck), .pl_nck(pl_nck),
		.ddr_ck_run(ddr_ck_run), .ddr_cke(ddr_cke), .ddr_cs_n(ddr_cs_n), .ddr_op(ddr_op),
		.ddr_bank(ddr_bank));
	ddrc_mem_model u_mem (.clk(clk), .sys_rst(sys_rst), .ddr_cke(ddr_cke), .ddr_op(ddr_op),
		.path_on(path_on), .n_seen(n_seen));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) cyc <= cyc + 1;

	task automatic chk(input string what, input bit ok, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (!ok) begin
			mismatches++;
			$display("mismatch %s expected %0d seen %0d", what, e, g);
		end
	endtask

	task automatic test_done;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	// Pin history is taken a little after each rising edge, once the outputs settle.
	always begin
		@(posedge clk);
		#10;
		if (ddr_cs_n === 1'b0) cs_cyc = cyc;
		if (ddr_cke === 1'b1 && ck_p === 1'b0) up_cyc = cyc;
		if (ddr_ck_run === 1'b1 && rn_p === 1'b0) run_cyc = cyc;
		if (ddr_ck_run === 1'b0 && rn_p === 1'b1)
			chk("clock keep", cyc - t_mrs >= CKMPE_CYC, CKMPE_CYC, cyc - t_mrs);
		ck_p = ddr_cke;
		rn_p = ddr_ck_run;
	end

	function automatic int earliest(input ddrc_op_t op, input logic [3:0] b, input logic d);
		int e;
		int dal;
		e = t_mrs + ((op == OP_MRS || op == OP_DEEP_ENTER) ? MRD_NCK : MOD_CYC);
		if (t_rd + MPR_RD_NCK + MPRR_NCK > e) e = t_rd + MPR_RD_NCK + MPRR_NCK;
		if (t_mw + MOD_CYC + mw_lat > e) e = t_mw + MOD_CYC + mw_lat;
		// Signed sum, so that a bank never written does not turn the compare unsigned.
		dal = wra[b] + int'(wr_nck) + RP_CYC;
		if (op == OP_ACT && dal > e) e = dal;
		if (x_cyc + XMP + (d ? DLLK_NCK : 0) > e) e = x_cyc + XMP + (d ? DLLK_NCK : 0);
		return e;
	endfunction

	task automatic send(input ddrc_op_t op, input logic [3:0] b, input logic d);
		int n;
		int e;
		e = earliest(op, b, d);
		@(negedge clk);
		cmd_valid = 1'b1;
		cmd_op = op;
		cmd_bank = b;
		cmd_dll = d;
		n = 0;
		while (cmd_ready !== 1'b1 && n < 2000) begin
			@(negedge clk);
			n++;
		end
		chk("ready wait", n < 2000, 2000, n);
		@(negedge clk);
		cmd_valid = 1'b0;
		if (op == OP_DEEP_EXIT) return;
		n = 0;
		while (cmd_issued !== 1'b1 && n < 20) begin
			@(negedge clk);
			n++;
		end
		chk("op", ddr_op === ((op == OP_DEEP_ENTER) ? OP_MRS : op), op, ddr_op);
		chk("issue latency", n == (cal_en ? CAL_CYC : 0), CAL_CYC, n);
		chk("bank", ddr_bank === b, b, ddr_bank);
		chk("spacing", cyc >= e, e, cyc);
		chk("select lead", cyc - cs_cyc >= (cal_en ? CAL_CYC : 0), CAL_CYC, cyc - cs_cyc);
		n_iss++;
		case (op)
			OP_MRS, OP_DEEP_ENTER: t_mrs = cyc;
			OP_MPR_RD: t_rd = cyc;
			OP_MPR_WR: begin
				t_mw = cyc;
				mw_lat = al_nck + pl_nck;
			end
			OP_WRA: wra[b] = cyc;
			default: ;
		endcase
	endtask

	task automatic settle(input logic c, input logic [4:0] w, input logic [4:0] a, input logic [3:0] p);
		repeat (80) @(negedge clk);
		cal_en = c;
		wr_nck = w;
		al_nck = a;
		pl_nck = p;
	endtask

	task automatic burst(input int cnt);
		ddrc_op_t ops[6] = '{OP_MRS, OP_MPR_RD, OP_MPR_WR, OP_WRA, OP_ACT, OP_OTHER};
		for (int i = 0; i < cnt; i++) send(ops[$urandom_range(5)], 4'($urandom), 1'($urandom_range(1)));
	endtask

	task automatic deep(input logic d);
		int n;
		send(OP_DEEP_ENTER, 4'h0, 1'b0);
		repeat (CKMPE_CYC + 4) @(negedge clk);
		chk("deep pins", {ddr_ck_run, ddr_cke, path_on} === 3'b000, 0, {ddr_ck_run, ddr_cke});
		send(OP_DEEP_EXIT, 4'h0, 1'b0);
		n = 0;
		while (ddr_cke !== 1'b1 && n < 40) begin
			@(negedge clk);
			n++;
		end
		chk("clock ready", up_cyc - run_cyc >= CKMPX_CYC, CKMPX_CYC, up_cyc - run_cyc);
		chk("select setup", up_cyc - cs_cyc >= MPX_S_CYC, MPX_S_CYC, up_cyc - cs_cyc);
		x_cyc = up_cyc;
		send(OP_OTHER, 4'h2, d);
		chk("select hold", cs_cyc - up_cyc >= XP_CYC, XP_CYC, cs_cyc - up_cyc);
	endtask

	initial begin
		ddrc_op_t   dop[10] = '{OP_MRS, OP_MRS, OP_OTHER, OP_MPR_RD, OP_ACT, OP_MPR_WR, OP_OTHER,
			OP_WRA, OP_ACT, OP_ACT};
		logic [3:0] dbk[10] = '{4'h1, 4'h2, 4'h0, 4'h0, 4'h4, 4'h0, 4'h0, 4'h3, 4'h3, 4'h5};
		void'($urandom(32'hf21e4f19));
		{sys_rst, cmd_valid, cmd_dll, cal_en, cmd_op, cmd_bank} = {4'h8, OP_DES, 4'h0};
		{wr_nck, al_nck, pl_nck} = {5'h0c, 5'h03, 4'h2};
		t_mrs = -3000;
		t_rd = -3000;
		t_mw = -3000;
		x_cyc = -3000;
		mw_lat = 0;
		n_iss = 0;
		mismatches = 0;
		total_checks = 0;
		foreach (wra[i]) wra[i] = -3000;
		repeat (4) @(negedge clk);
		chk("reset pins", {cmd_ready, cmd_issued, ddr_ck_run, ddr_cke, ddr_cs_n} === 5'h07
			&& ddr_op === OP_DES && ddr_bank === 4'h0, 7, ddr_op);
		sys_rst = 1'b0;
		for (int i = 0; i < 10; i++) send(dop[i], dbk[i], 1'b0);
		for (int k = 0; k < 3; k++) begin
			settle(k[0], 5'($urandom_range(31)), 5'($urandom_range(15)), 4'($urandom_range(7)));
			burst(25);
		end
		settle(1'b0, 5'h0a, 5'h00, 4'h0);
		deep(1'b0);
		burst(10);
		deep(1'b1);
		repeat (5) @(negedge clk);
		chk("commands seen", n_seen === n_iss, n_iss, n_seen);
		test_done;
	end

	initial begin
		repeat (30000) @(posedge clk);
		mismatches++;
		test_done;
	end
endmodule
`default_nettype wire
